// ===== logic/branch_call_skip_unit.sv
`timescale 1ns/10ps
// Notes on behaviour
// - pointer call: push return, pc from z, upper bits zero, 2/3 cycles
// - far pointer call: pc from page and z, push return, 3 cycles
// - equal skip: skip next when operands equal, 1/2/3 cycles
// - register bit skip on clear or set bit, 1/2/3 cycles, no flags
// - i/o bit skip on clear or set bit, 2/3/4 cycles, no flags
// - flag bit jump: pc plus offset plus one, taken 2, else 1
// - carry jumps on carry set or clear, 1/2 cycles
// - unsigned ge on carry clear, unsigned lt on carry set
// - signed ge when n xor v zero, lt when one
// - half carry jumps, 1/2 cycles, flags kept
// - t flag jumps, 1/2 cycles
// - overflow jumps, 1/2 cycles
// - interrupt flag jumps, flag untouched, 1/2 cycles
module branch_call_skip_unit
    import flow_pkg::*;
#(
    parameter int PC_WIDTH = 22
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [31:0] bus_rdata,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] instr_ext,
    input wire logic next_two_word,
    input wire logic [7:0] rd_value,
    input wire logic [7:0] rr_value,
    input wire logic [7:0] io_value,
    input wire logic [PC_WIDTH-1:0] stack_pop_data,
    output logic instr_ready,
    output logic exec_done,
    output logic [PC_WIDTH-1:0] pc,
    output logic [7:0] flag_word,
    output logic stack_push,
    output logic [PC_WIDTH-1:0] stack_push_data,
    output logic stack_pop
);

    // ==========================================================
    // sequencer state
    // ==========================================================
    typedef enum logic {
        SEQ_IDLE = 1'b0,
        SEQ_RUN = 1'b1
    } seq_e;

    seq_e seq;
    logic [2:0] remain;
    logic [2:0] last_cycles;
    logic [PC_WIDTH-1:0] pend_target;
    logic [7:0] pend_flags;
    logic pend_pop;
    logic pend_isr;
    logic [15:0] z_pointer;
    logic [5:0] far_jump_page;

    // ==========================================================
    // decode
    // ==========================================================
    exec_if ex ();

    op_e op;
    logic accept;
    logic commit;
    logic [2:0] call_extra;
    logic [PC_WIDTH-1:0] rel_long;
    logic [PC_WIDTH-1:0] rel_short;
    logic [PC_WIDTH-1:0] skip_target;
    logic [2:0] skip_cycles;
    logic [PC_WIDTH-1:0] next_target;
    logic [2:0] next_cycles;
    logic [7:0] next_flags;
    logic next_push;
    logic [PC_WIDTH-1:0] next_ret;
    logic next_pop;
    logic next_isr;

    assign op = op_e'(instr[15:11]);
    assign accept = instr_valid & instr_ready;
    assign commit = (seq == SEQ_RUN) & (remain == 3'h0);

    // a counter wider than a word needs one more stack cycle
    assign call_extra = (PC_WIDTH > NARROW_PC_BITS) ? 3'h1 : 3'h0;
    assign rel_long = pc + PC_WIDTH'($signed(instr[10:0]))
                    + PC_WIDTH'(1);
    assign rel_short = pc + PC_WIDTH'($signed(instr[6:0]))
                     + PC_WIDTH'(1);
    assign skip_target = pc + (next_two_word ? PC_WIDTH'(3) : PC_WIDTH'(2));
    assign skip_cycles = next_two_word ? 3'h3 : 3'h2;

    assign ex.op = op;
    assign ex.flags = flag_word;
    assign ex.rd_val = rd_value;
    assign ex.rr_val = rr_value;
    assign ex.io_val = io_value;
    assign ex.imm = instr[7:0];
    assign ex.sel = (op == OP_FLAG_BIT_SET_JUMP
                     || op == OP_FLAG_BIT_CLEAR_JUMP)
                  ? instr[9:7] : instr[2:0];

    branch_condition cond_unit (
        .ex(ex.cond)
    );

    compare_flags cmp_unit (
        .ex(ex.cmp)
    );

    always_comb begin
        next_target = pc + PC_WIDTH'(1);
        next_cycles = CYC_SINGLE;
        next_flags = flag_word;
        next_push = 1'b0;
        next_ret = pc + PC_WIDTH'(1);
        next_pop = 1'b0;
        next_isr = 1'b0;
        case (op)
            OP_NEAR_SUBCALL: begin
                next_target = rel_long;
                next_cycles = CYC_NEAR_CALL + call_extra;
                next_push = 1'b1;
            end
            OP_POINTER_SUBCALL: begin
                // upper counter bits forced to zero
                next_target = PC_WIDTH'(z_pointer);
                next_cycles = CYC_PTR_CALL + call_extra;
                next_push = 1'b1;
            end
            OP_FAR_POINTER_SUBCALL: begin
                next_target = PC_WIDTH'({far_jump_page, z_pointer});
                next_cycles = CYC_FAR_CALL;
                next_push = 1'b1;
            end
            OP_ABS_SUBCALL: begin
                // absolute call, return past both words
                next_target = PC_WIDTH'({instr[5:0], instr_ext});
                next_cycles = CYC_ABS_CALL + call_extra;
                next_push = 1'b1;
                next_ret = pc + PC_WIDTH'(2);
            end
            OP_SUB_EXIT: begin
                next_cycles = CYC_RETURN + call_extra;
                next_pop = 1'b1;
            end
            OP_ISR_EXIT: begin
                next_cycles = CYC_RETURN + call_extra;
                next_pop = 1'b1;
                next_isr = 1'b1;
            end
            OP_REG_COMPARE, OP_CARRY_COMPARE, OP_IMM_COMPARE: begin
                next_flags = ex.cmp_flags;
            end
            OP_EQUAL_SKIP, OP_REG_BIT_CLEAR_SKIP, OP_REG_BIT_SET_SKIP: begin
                if (ex.taken) begin
                    next_target = skip_target;
                    next_cycles = skip_cycles;
                end
            end
            OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP: begin
                // i/o read costs one more cycle
                next_cycles = CYC_SINGLE + CYC_IO_EXTRA;
                if (ex.taken) begin
                    next_target = skip_target;
                    next_cycles = skip_cycles + CYC_IO_EXTRA;
                end
            end
            OP_FLAG_BIT_SET_JUMP, OP_FLAG_BIT_CLEAR_JUMP,
            OP_UNSIGNED_GE_JUMP, OP_UNSIGNED_LT_JUMP,
            OP_SIGNED_GE_JUMP, OP_SIGNED_LT_JUMP: begin
                if (ex.taken) begin
                    next_target = rel_short;
                    next_cycles = CYC_BRANCH_TAKEN;
                end
            end
            default: begin
                next_target = pc + PC_WIDTH'(1);
            end
        endcase
    end

    // ==========================================================
    // execution sequencer
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            seq <= SEQ_IDLE;
            remain <= 3'h0;
            instr_ready <= 1'b0;
        end else begin
            case (seq)
                SEQ_IDLE: begin
                    instr_ready <= 1'b1;
                    if (accept) begin
                        seq <= SEQ_RUN;
                        remain <= next_cycles - 3'h1;
                        instr_ready <= 1'b0;
                    end
                end
                SEQ_RUN: begin
                    if (remain == 3'h0) begin
                        seq <= SEQ_IDLE;
                        instr_ready <= 1'b1;
                    end else begin
                        remain <= remain - 3'h1;
                    end
                end
                default: begin
                    seq <= SEQ_IDLE;
                end
            endcase
        end
    end

    // held until commit so pc and flag word land at once; stack strobes fire the cycle after accept
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pend_target <= '0;
            pend_flags <= FLAGS_RESET;
            pend_pop <= 1'b0;
            pend_isr <= 1'b0;
            last_cycles <= 3'h0;
        end else if (accept) begin
            pend_target <= next_target;
            pend_flags <= next_flags;
            pend_pop <= next_pop;
            pend_isr <= next_isr;
            last_cycles <= next_cycles;
        end
    end

    // ==========================================================
    // stack strobes
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            stack_push <= 1'b0;
            stack_push_data <= '0;
            stack_pop <= 1'b0;
        end else begin
            stack_push <= accept & next_push;
            stack_pop <= accept & next_pop;
            if (accept & next_push) begin
                stack_push_data <= next_ret;
            end
        end
    end

    // ==========================================================
    // program counter and flag word
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pc <= '0;
            exec_done <= 1'b0;
        end else begin
            exec_done <= commit;
            if (commit) begin
                // stack word read at the last cycle
                pc <= pend_pop ? stack_pop_data : pend_target;
            end else if (bus_write && bus_addr == REG_PC) begin
                pc <= PC_WIDTH'(bus_wdata);
            end
        end
    end

    // a commit beats a software write in the same cycle
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            flag_word <= FLAGS_RESET;
        end else if (commit) begin
            flag_word <= pend_flags;
            // isr exit sets the interrupt flag
            if (pend_isr) begin
                flag_word[FLAG_I] <= 1'b1;
            end
        end else if (bus_write && bus_addr == REG_FLAGS) begin
            flag_word <= bus_wdata[7:0];
        end
    end

    // ==========================================================
    // register port
    // ==========================================================
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            z_pointer <= ZPTR_RESET;
            far_jump_page <= PAGE_RESET;
        end else if (bus_write) begin
            if (bus_addr == REG_ZPTR) begin
                z_pointer <= bus_wdata[15:0];
            end
            if (bus_addr == REG_PAGE) begin
                far_jump_page <= bus_wdata[5:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            bus_rdata <= 32'h00000000;
        end else if (bus_read) begin
            case (bus_addr)
                REG_FLAGS: bus_rdata <= {24'h000000, flag_word};
                REG_ZPTR: bus_rdata <= {16'h0000, z_pointer};
                REG_PAGE: bus_rdata <= {26'h0000000, far_jump_page};
                REG_PC: bus_rdata <= 32'(pc);
                REG_STATUS: bus_rdata <= {28'h0000000, last_cycles,
                                          seq == SEQ_RUN};
                default: bus_rdata <= 32'h00000000;
            endcase
        end else begin
            // data stands only in the cycle after the read
            bus_rdata <= 32'h00000000;
        end
    end

endmodule : branch_call_skip_unit

// ===== logic/flow_pkg.sv
package flow_pkg;

    // ==========================================================
    // operation codes, carried in instruction bits 15:11
    // ==========================================================
    typedef enum logic [4:0] {
        OP_NONE = 5'b00000,
        OP_NEAR_SUBCALL = 5'b00001,
        OP_POINTER_SUBCALL = 5'b00010,
        OP_FAR_POINTER_SUBCALL = 5'b00011,
        OP_ABS_SUBCALL = 5'b00100,
        OP_SUB_EXIT = 5'b00101,
        OP_ISR_EXIT = 5'b00110,
        OP_EQUAL_SKIP = 5'b00111,
        OP_REG_COMPARE = 5'b01000,
        OP_CARRY_COMPARE = 5'b01001,
        OP_IMM_COMPARE = 5'b01010,
        OP_REG_BIT_CLEAR_SKIP = 5'b01011,
        OP_REG_BIT_SET_SKIP = 5'b01100,
        OP_IO_BIT_CLEAR_SKIP = 5'b01101,
        OP_IO_BIT_SET_SKIP = 5'b01110,
        OP_FLAG_BIT_SET_JUMP = 5'b01111,
        OP_FLAG_BIT_CLEAR_JUMP = 5'b10000,
        OP_UNSIGNED_GE_JUMP = 5'b10001,
        OP_UNSIGNED_LT_JUMP = 5'b10010,
        OP_SIGNED_GE_JUMP = 5'b10011,
        OP_SIGNED_LT_JUMP = 5'b10100,
        OP_PAIR_COPY = 5'b10101
    } op_e;

    // ==========================================================
    // flag word bit positions
    // ==========================================================
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ==========================================================
    // register map and reset values
    // ==========================================================
    localparam logic [7:0] REG_FLAGS = 8'h00;
    localparam logic [7:0] REG_ZPTR = 8'h04;
    localparam logic [7:0] REG_PAGE = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] ZPTR_RESET = 16'h0000;
    localparam logic [5:0] PAGE_RESET = 6'h00;

    // ==========================================================
    // cycle counts
    // ==========================================================
    localparam logic [2:0] CYC_SINGLE = 3'h1;
    localparam logic [2:0] CYC_NEAR_CALL = 3'h2;
    localparam logic [2:0] CYC_PTR_CALL = 3'h2;
    localparam logic [2:0] CYC_FAR_CALL = 3'h3;
    localparam logic [2:0] CYC_ABS_CALL = 3'h3;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    localparam logic [2:0] CYC_BRANCH_TAKEN = 3'h2;
    localparam logic [2:0] CYC_IO_EXTRA = 3'h1;
    localparam int NARROW_PC_BITS = 16;

endpackage : flow_pkg

// ===== logic/exec_if.sv
`timescale 1ns/10ps
interface exec_if;
    import flow_pkg::*;
    op_e op;
    logic [2:0] sel;
    logic [7:0] flags;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] io_val;
    logic [7:0] imm;
    logic taken;
    logic [7:0] cmp_flags;

    modport core (output op, sel, flags, rd_val, rr_val, io_val, imm,
                  input taken, cmp_flags);
    modport cond (input op, sel, flags, rd_val, rr_val, io_val,
                  output taken);
    modport cmp (input op, flags, rd_val, rr_val, imm,
                 output cmp_flags);
endinterface : exec_if

// ===== logic/branch_condition.sv
`timescale 1ns/10ps
module branch_condition
    import flow_pkg::*;
(
    exec_if.cond ex
);

    always_comb begin
        case (ex.op)
            OP_EQUAL_SKIP: ex.taken = (ex.rd_val == ex.rr_val);
            OP_REG_BIT_CLEAR_SKIP: ex.taken = ~ex.rr_val[ex.sel];
            OP_REG_BIT_SET_SKIP: ex.taken = ex.rr_val[ex.sel];
            OP_IO_BIT_CLEAR_SKIP: ex.taken = ~ex.io_val[ex.sel];
            OP_IO_BIT_SET_SKIP: ex.taken = ex.io_val[ex.sel];
            // selected flag test
            // carry, half, t, overflow and interrupt forms select a bit
            // flag aliases
            OP_FLAG_BIT_SET_JUMP: ex.taken = ex.flags[ex.sel];
            OP_FLAG_BIT_CLEAR_JUMP: ex.taken = ~ex.flags[ex.sel];
            OP_UNSIGNED_GE_JUMP: ex.taken = ~ex.flags[FLAG_C];
            OP_UNSIGNED_LT_JUMP: ex.taken = ex.flags[FLAG_C];
            OP_SIGNED_GE_JUMP:
                ex.taken = ~(ex.flags[FLAG_N] ^ ex.flags[FLAG_V]);
            OP_SIGNED_LT_JUMP: ex.taken = ex.flags[FLAG_N] ^ ex.flags[FLAG_V];
            default: ex.taken = 1'b0;
        endcase
    end

endmodule : branch_condition

// ===== logic/compare_flags.sv
`timescale 1ns/10ps
module compare_flags
    import flow_pkg::*;
(
    exec_if.cmp ex
);

    logic [7:0] subtrahend;
    logic borrow_in;
    logic [7:0] diff;
    logic new_v;

    assign subtrahend = (ex.op == OP_IMM_COMPARE) ? ex.imm : ex.rr_val;
    assign borrow_in = (ex.op == OP_CARRY_COMPARE) & ex.flags[FLAG_C];
    assign diff = ex.rd_val - subtrahend - {7'h00, borrow_in};
    assign new_v = (ex.rd_val[7] & ~subtrahend[7] & ~diff[7])
                 | (~ex.rd_val[7] & subtrahend[7] & diff[7]);

    always_comb begin
        ex.cmp_flags = ex.flags;
        ex.cmp_flags[FLAG_C] = (~ex.rd_val[7] & subtrahend[7])
                             | (subtrahend[7] & diff[7])
                             | (diff[7] & ~ex.rd_val[7]);
        // with carry, zero only survives a previous zero
        ex.cmp_flags[FLAG_Z] = (diff == 8'h00)
            & ((ex.op != OP_CARRY_COMPARE) | ex.flags[FLAG_Z]);
        ex.cmp_flags[FLAG_N] = diff[7];
        ex.cmp_flags[FLAG_V] = new_v;
        ex.cmp_flags[FLAG_S] = diff[7] ^ new_v;
        ex.cmp_flags[FLAG_H] = (~ex.rd_val[3] & subtrahend[3])
                             | (subtrahend[3] & diff[3])
                             | (diff[3] & ~ex.rd_val[3]);
    end

endmodule : compare_flags

// ===== verif/branch_call_skip_unit_chk.sv
`timescale 1ns/10ps
module branch_call_skip_unit_chk
    import flow_pkg::*;
#(
    parameter int PC_WIDTH = 22
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic instr_ready,
    input wire logic exec_done,
    input wire logic [PC_WIDTH-1:0] pc,
    input wire logic [7:0] flag_word,
    input wire logic stack_push,
    input wire logic stack_pop
);
    logic acc;
    logic [4:0] opc;
    assign acc = instr_valid && instr_ready;
    assign opc = instr[15:11];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // timing of accepted instructions
    // ==========================================================
    // busy after accept
    a_ready_drop: assert property (
        acc |=> !instr_ready) else $error("ready high after accept");
    a_done_pulse: assert property (
        exec_done |=> !exec_done) else $error("done longer than one cycle");
    a_cmp_one: assert property (
        acc && opc inside {[OP_REG_COMPARE:OP_IMM_COMPARE]} |-> ##2 exec_done)
        else $error("compare not done in one cycle");
    a_branch_time: assert property (
        acc && opc inside {[OP_FLAG_BIT_SET_JUMP:OP_SIGNED_LT_JUMP]}
        |-> ##[2:3] exec_done) else $error("branch cycle count wrong");
    a_flags_kept: assert property (
        acc && opc inside {[OP_FLAG_BIT_SET_JUMP:OP_SIGNED_LT_JUMP]}
        |=> $stable(flag_word) [*2]) else $error("branch changed flags");
    a_near_time: assert property (
        acc && opc == OP_NEAR_SUBCALL |-> ##4 exec_done)
        else $error("near call cycle count wrong");
    a_push_call: assert property (
        acc && opc inside {[OP_NEAR_SUBCALL:OP_ABS_SUBCALL]}
        |=> stack_push ##1 !stack_push) else $error("call push missing");
    a_pop_return: assert property (
        acc && opc inside {[OP_SUB_EXIT:OP_ISR_EXIT]} |=> stack_pop)
        else $error("return pop missing");
    a_ret_hold: assert property (
        acc && opc == OP_SUB_EXIT |=> $stable(pc) [*5] ##1 exec_done)
        else $error("return pc or timing wrong");
    a_isr_sets_i: assert property (
        acc && opc == OP_ISR_EXIT |-> ##6 flag_word[FLAG_I])
        else $error("isr exit left interrupt flag clear");
endmodule : branch_call_skip_unit_chk

bind branch_call_skip_unit branch_call_skip_unit_chk #(
    .PC_WIDTH(PC_WIDTH)
) chk (
    .clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .exec_done(exec_done),
    .pc(pc), .flag_word(flag_word), .stack_push(stack_push),
    .stack_pop(stack_pop)
);

// ===== verif/branch_call_skip_unit_test.sv
`timescale 1ns/10ps
module branch_call_skip_unit_test;
    import flow_pkg::*;
    localparam int PW = 22;
    logic clock, reset_n, bus_write, bus_read, instr_valid, next_two_word;
    logic [7:0] bus_addr, rd_value, rr_value, io_value, flag_word, m_fl, e_fl;
    logic [31:0] bus_wdata, bus_rdata, rv;
    logic [15:0] instr, instr_ext, m_z;
    logic [PW-1:0] stack_pop_data, pc, stack_push_data, m_pc, e_pc, e_pd;
    logic instr_ready, exec_done, stack_push, stack_pop;
    logic [5:0] m_page;
    int n_mismatch = 0;
    int num_checks = 0;
    integer seed = 32'h979BE0AC;
    int e_n;
    bit e_push, e_pop;
    op_e sops[5] = '{OP_EQUAL_SKIP, OP_REG_BIT_CLEAR_SKIP,
        OP_REG_BIT_SET_SKIP, OP_IO_BIT_CLEAR_SKIP, OP_IO_BIT_SET_SKIP};
    int cyc[6] = '{3, 3, 3, 4, 5, 5};

    branch_call_skip_unit uut (
        .clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
        .bus_rdata(bus_rdata), .instr_valid(instr_valid), .instr(instr),
        .instr_ext(instr_ext), .next_two_word(next_two_word),
        .rd_value(rd_value), .rr_value(rr_value), .io_value(io_value),
        .stack_pop_data(stack_pop_data), .instr_ready(instr_ready),
        .exec_done(exec_done), .pc(pc), .flag_word(flag_word),
        .stack_push(stack_push), .stack_push_data(stack_push_data),
        .stack_pop(stack_pop)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // ==========================================================
    // shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // idle edge so a strobe is never set and cleared at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge clock);
        bus_write <= 1'b0;
        @(posedge clock);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge clock);
        bus_read <= 1'b0;
        @(posedge clock);
        d = bus_rdata;
    endtask : rd

    task automatic setup(input logic [PW-1:0] p, input logic [7:0] f);
        wr(REG_PC, 32'(p));
        wr(REG_FLAGS, 32'(f));
        m_pc = p;
        m_fl = f;
        e_fl = f;
        {e_push, e_pop, e_pd} = '0;
    endtask : setup

    task automatic run(input logic [15:0] ins, input logic [15:0] ext);
        int n = 0;
        bit pushed = 1'b0;
        bit popped = 1'b0;
        logic [PW-1:0] pd = '0;
        instr <= ins;
        instr_ext <= ext;
        instr_valid <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (instr_ready !== 1'b1 && n < 20);
        instr_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
            if (stack_push === 1'b1) begin
                pushed = 1'b1;
                pd = stack_push_data;
            end
            if (stack_pop === 1'b1) popped = 1'b1;
        end while (exec_done !== 1'b1 && n < 20);
        check("cycles", 32'(n - 1), 32'(e_n));
        check("pc", 32'(pc), 32'(e_pc));
        check("flags", 32'(flag_word), 32'(e_fl));
        check("stack", {popped, pushed, pd}, {e_pop, e_push, e_pd});
    endtask : run

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        print_verdict();
    end

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        reset_n = 1'b0;
        {bus_addr, bus_wdata, bus_write, bus_read, instr_valid} = '0;
        {instr, instr_ext, next_two_word, stack_pop_data} = '0;
        {rd_value, rr_value, io_value} = '0;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check("pc_reset", 32'(pc), 32'h0);
        for (int a = 0; a < 5; a++) begin
            rd(8'(a * 4), rv);
            check("reg_reset", rv, 32'h0);
        end
        wr(8'hF0, 32'hFFFFFFFF);
        rd(8'hF0, rv);
        check("unmapped", rv, 32'h0);
        rd(REG_FLAGS, rv);
        check("flags_kept", rv, 32'h0);
        m_z = 16'($random(seed));
        m_page = 6'($random(seed));
        wr(REG_ZPTR, 32'(m_z));
        wr(REG_PAGE, 32'(m_page));
        rd(REG_PAGE, rv);
        check("page", rv, 32'(m_page));
        for (int i = 0; i < 96; i++) begin
            op_e o;
            logic [2:0] s;
            logic [6:0] k;
            bit t;
            o = op_e'(OP_FLAG_BIT_SET_JUMP + i / 16);
            s = i[2:0];
            k = 7'($random(seed));
            setup(PW'($random(seed)), 8'($random(seed)));
            case (o)
                OP_FLAG_BIT_SET_JUMP: t = m_fl[s];
                OP_FLAG_BIT_CLEAR_JUMP: t = !m_fl[s];
                OP_UNSIGNED_GE_JUMP: t = !m_fl[FLAG_C];
                OP_UNSIGNED_LT_JUMP: t = m_fl[FLAG_C];
                OP_SIGNED_GE_JUMP: t = !(m_fl[FLAG_N] ^ m_fl[FLAG_V]);
                default: t = m_fl[FLAG_N] ^ m_fl[FLAG_V];
            endcase
            e_n = t ? 2 : 1;
            e_pc = m_pc + 1 + (t ? {{15{k[6]}}, k} : '0);
            run({o, 1'b0, s, k}, 16'h0000);
        end
        for (int i = 0; i < 40; i++) begin
            op_e o;
            logic [2:0] b;
            logic [7:0] a, r, io;
            bit sk;
            o = sops[i / 8];
            b = 3'($random(seed));
            r = 8'($random(seed));
            a = (o != OP_EQUAL_SKIP || i[1]) ? r : 8'($random(seed));
            io = 8'($random(seed));
            setup(PW'($random(seed)), 8'($random(seed)));
            case (o)
                OP_EQUAL_SKIP: sk = (a == r);
                OP_REG_BIT_CLEAR_SKIP: sk = !r[b];
                OP_REG_BIT_SET_SKIP: sk = r[b];
                OP_IO_BIT_CLEAR_SKIP: sk = !io[b];
                default: sk = io[b];
            endcase
            e_n = 1 + (i >= 24) + (sk ? 1 + i[0] : 0);
            e_pc = m_pc + 1 + (sk ? 1 + i[0] : 0);
            rd_value <= a;
            rr_value <= r;
            io_value <= io;
            next_two_word <= i[0];
            run({o, 8'h00, b}, 16'h0000);
        end
        for (int i = 0; i < 24; i++) begin
            op_e o;
            logic [7:0] a, b8, r;
            logic [8:0] d;
            logic [4:0] h;
            bit c, v;
            o = op_e'(OP_REG_COMPARE + i % 3);
            a = 8'($random(seed));
            b8 = (i % 4 == 0) ? a : 8'($random(seed));
            setup(PW'($random(seed)), 8'($random(seed)));
            c = o == OP_CARRY_COMPARE && m_fl[FLAG_C];
            d = {1'b0, a} - {1'b0, b8} - 9'(c);
            h = {1'b0, a[3:0]} - {1'b0, b8[3:0]} - 5'(c);
            r = d[7:0];
            v = (a[7] != b8[7]) && (r[7] != a[7]);
            e_fl[FLAG_C] = d[8];
            e_fl[FLAG_Z] = (r == 0) && (o != OP_CARRY_COMPARE || m_fl[1]);
            e_fl[FLAG_N] = r[7];
            e_fl[FLAG_V] = v;
            e_fl[FLAG_S] = r[7] ^ v;
            e_fl[FLAG_H] = h[4];
            e_n = 1;
            e_pc = m_pc + 1;
            rd_value <= a;
            rr_value <= b8;
            run({o, 3'b000, b8}, 16'h0000);
        end
        for (int i = 0; i < 24; i++) begin
            op_e o;
            logic [10:0] k;
            logic [15:0] ext;
            logic [PW-1:0] ret;
            o = op_e'(OP_NEAR_SUBCALL + i % 6);
            k = 11'($random(seed));
            ext = 16'($random(seed));
            ret = PW'($random(seed));
            setup(PW'($random(seed)), 8'($random(seed)));
            e_push = (i % 6) < 4;
            e_pop = !e_push;
            e_pd = e_push ? PW'(m_pc + 1 + (o == OP_ABS_SUBCALL)) : '0;
            case (o)
                OP_NEAR_SUBCALL: e_pc = m_pc + 1 + {{11{k[10]}}, k};
                OP_POINTER_SUBCALL: e_pc = {6'h00, m_z};
                OP_FAR_POINTER_SUBCALL: e_pc = {m_page, m_z};
                OP_ABS_SUBCALL: e_pc = {k[5:0], ext};
                default: e_pc = ret;
            endcase
            if (o == OP_ISR_EXIT) e_fl[FLAG_I] = 1'b1;
            e_n = cyc[i % 6];
            stack_pop_data <= ret;
            run({o, k}, ext);
        end
        rd(REG_STATUS, rv);
        check("status", rv, 32'h0000000A);
        print_verdict();
    end
endmodule : branch_call_skip_unit_test
